// [logic/pfs_pkg.sv]
// constants shared by the program flow and stack register block
`default_nettype none

package pfs_pkg;

    // ***************************************************************
    // widths
    // ***************************************************************
    localparam int unsigned PFS_APB_AW = 8;
    localparam int unsigned PFS_APB_DW = 32;
    localparam int unsigned PFS_REG_W = 16;
    localparam int unsigned PFS_SP_W = 6;

    // ***************************************************************
    // register byte offsets on the bus
    // ***************************************************************
    localparam logic [PFS_APB_AW-1:0] PFS_OFF_IP = 8'h00;
    localparam logic [PFS_APB_AW-1:0] PFS_OFF_SP = 8'h04;
    localparam logic [PFS_APB_AW-1:0] PFS_OFF_VEC = 8'h08;
    localparam logic [PFS_APB_AW-1:0] PFS_OFF_LOOP = 8'h0C;

    // ***************************************************************
    // reset values, steps and stack pointer limits
    // ***************************************************************
    localparam logic [PFS_REG_W-1:0] PFS_IP_RST = 16'h8000;
    localparam logic [PFS_REG_W-1:0] PFS_SP_RST = 16'h002F;
    localparam logic [PFS_REG_W-1:0] PFS_VEC_RST = 16'h07FD;
    localparam logic [PFS_REG_W-1:0] PFS_LOOP_RST = 16'h0000;
    localparam logic [PFS_REG_W-1:0] PFS_IP_STEP = 16'h0001;
    localparam logic [PFS_SP_W-1:0] PFS_SP_STEP = 6'h01;
    localparam logic [PFS_SP_W-1:0] PFS_SP_MAX = 6'h3F;
    localparam logic [PFS_SP_W-1:0] PFS_SP_MIN = 6'h00;

endpackage

`default_nettype wire

// [logic/pfs_stack_mem.sv]
// flip-flop stack storage, one write port and one read port
`timescale 1ns/1ps
`default_nettype none

module pfs_stack_mem
    import pfs_pkg::*;
#(
    parameter int unsigned WIDTH = PFS_REG_W,
    parameter int unsigned AW = PFS_SP_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    localparam int unsigned DEPTH = 1 << AW;

    logic [WIDTH-1:0] mem_q [DEPTH];

    // ***************************************************************
    // one word per entry
    // ***************************************************************
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem_q[i] <= '0;
            end else if (wr_en && (wr_addr == AW'(i))) begin
                mem_q[i] <= wr_data;
            end
        end
    end

    assign rd_data = mem_q[rd_addr];

endmodule

`default_nettype wire

// [logic/pfs_flow_regs.sv]
// program flow registers: fetch pointer, stack pointer, vector, loop count
`timescale 1ns/1ps
`default_nettype none

module pfs_flow_regs
    import pfs_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [PFS_APB_AW-1:0] PADDR,
    input wire logic [PFS_APB_DW-1:0] PWDATA,
    output logic [PFS_APB_DW-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic FETCH_STROBE,
    output logic [PFS_REG_W-1:0] FETCH_ADDR,
    input wire logic PUSH_STROBE,
    input wire logic [PFS_REG_W-1:0] PUSH_DATA,
    input wire logic POP_STROBE,
    output logic [PFS_REG_W-1:0] POP_DATA,
    output logic [PFS_SP_W-1:0] STACK_TOP,
    input wire logic IRQ_PENDING,
    output logic IRQ_ACK,
    output logic [PFS_REG_W-1:0] LOOP_COUNT
);

    // ***************************************************************
    // declarations
    // ***************************************************************
    logic [PFS_REG_W-1:0] ip_q;
    logic [PFS_REG_W-1:0] ip_d;
    logic [PFS_SP_W-1:0] sp_q;
    logic [PFS_SP_W-1:0] sp_d;
    logic [PFS_REG_W-1:0] vec_q;
    logic [PFS_REG_W-1:0] loop_cnt_q;
    logic [PFS_APB_DW-1:0] prdata_q;
    logic [PFS_APB_DW-1:0] prdata_d;
    logic [PFS_REG_W-1:0] pop_data_q;
    logic [PFS_REG_W-1:0] stk_rd;
    logic [PFS_REG_W-1:0] stk_wdata;
    logic [PFS_REG_W-1:0] ret_addr;
    logic [PFS_SP_W-1:0] sp_inc;
    logic [PFS_SP_W-1:0] sp_dec;
    logic stk_we;
    logic setup_ph;
    logic access_ph;
    logic hit_ip;
    logic hit_sp;
    logic hit_vec;
    logic hit_loop;
    logic hit_any;
    logic wr_ok;
    logic wr_ip;
    logic wr_sp;
    logic wr_loop;
    logic call_go;
    logic push_go;
    logic pop_go;
    logic boot_q;

    // ***************************************************************
    // apb decode
    // ***************************************************************
    assign setup_ph = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;
    assign hit_ip = (PADDR == PFS_OFF_IP);
    assign hit_sp = (PADDR == PFS_OFF_SP);
    assign hit_vec = (PADDR == PFS_OFF_VEC);
    assign hit_loop = (PADDR == PFS_OFF_LOOP);
    assign hit_any = hit_ip || hit_sp || hit_vec || hit_loop;

    // zero wait state slave
    assign PREADY = 1'b1;

    assign PSLVERR = access_ph && (!hit_any || (PWRITE && hit_vec));

    assign wr_ok = access_ph && PWRITE;
    assign wr_ip = wr_ok && hit_ip;
    assign wr_sp = wr_ok && hit_sp;
    assign wr_loop = wr_ok && hit_loop;

    // ***************************************************************
    // read data, captured in the setup cycle
    // ***************************************************************
    always_comb begin
        prdata_d = '0;
        if (hit_ip) begin
            prdata_d = PFS_APB_DW'(ip_q);
        end else if (hit_sp) begin
            prdata_d = PFS_APB_DW'(sp_q);
        end else if (hit_vec) begin
            prdata_d = PFS_APB_DW'(vec_q);
        end else if (hit_loop) begin
            prdata_d = PFS_APB_DW'(loop_cnt_q);
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            prdata_q <= '0;
        end else if (setup_ph && !PWRITE) begin
            prdata_q <= prdata_d;
        end
    end

    assign PRDATA = prdata_q;

    // ***************************************************************
    // interrupt call and stack arbitration
    // ***************************************************************
    // call taken when no push, pop or bus write competes
    assign call_go = IRQ_PENDING && !PUSH_STROBE && !POP_STROBE && !wr_ok;
    assign IRQ_ACK = call_go;
    assign push_go = PUSH_STROBE && !wr_sp;
    assign pop_go = POP_STROBE && !PUSH_STROBE && !wr_sp;

    // return address skips a word fetched in the same cycle
    assign ret_addr = FETCH_STROBE ? (ip_q + PFS_IP_STEP) : ip_q;

    assign sp_inc = sp_q + PFS_SP_STEP;
    assign sp_dec = sp_q - PFS_SP_STEP;

    // store lands at the incremented pointer
    assign stk_we = push_go || call_go;
    assign stk_wdata = call_go ? ret_addr : PUSH_DATA;

    // ***************************************************************
    // fetch pointer
    // ***************************************************************
    always_comb begin
        ip_d = ip_q;
        if (call_go) begin
            ip_d = vec_q;
        end else if (wr_ip) begin
            ip_d = PWDATA[PFS_REG_W-1:0];
        end else if (FETCH_STROBE) begin
            ip_d = ip_q + PFS_IP_STEP;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ip_q <= PFS_IP_RST;
        end else begin
            ip_q <= ip_d;
        end
    end

    assign FETCH_ADDR = ip_q;

    // ***************************************************************
    // stack pointer
    // ***************************************************************
    always_comb begin
        sp_d = sp_q;
        if (wr_sp) begin
            sp_d = PWDATA[PFS_SP_W-1:0];
        end else if (stk_we) begin
            sp_d = sp_inc;
        end else if (pop_go) begin
            sp_d = sp_dec;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            sp_q <= PFS_SP_RST[PFS_SP_W-1:0];
        end else begin
            sp_q <= sp_d;
        end
    end

    assign STACK_TOP = sp_q;

    // ***************************************************************
    // stack storage
    // ***************************************************************
    // read port sits on the current top
    pfs_stack_mem #(
        .WIDTH(PFS_REG_W),
        .AW(PFS_SP_W)
    ) pfs_stack_mem_inst (
        .clk(CLOCK),
        .rst_n(RSTN),
        .wr_en(stk_we),
        .wr_addr(sp_inc),
        .wr_data(stk_wdata),
        .rd_addr(sp_q),
        .rd_data(stk_rd)
    );

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pop_data_q <= '0;
        end else if (pop_go) begin
            pop_data_q <= stk_rd;
        end
    end

    assign POP_DATA = pop_data_q;

    // ***************************************************************
    // vector and loop counter
    // ***************************************************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            vec_q <= PFS_VEC_RST;
        end else begin
            vec_q <= vec_q;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            loop_cnt_q <= PFS_LOOP_RST;
        end else if (wr_loop) begin
            loop_cnt_q <= PWDATA[PFS_REG_W-1:0];
        end
    end

    assign LOOP_COUNT = loop_cnt_q;

    // ***************************************************************
    // checks
    // ***************************************************************
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    default clocking cb @(posedge CLOCK);
    endclocking

    default disable iff (!RSTN);

    sequence s_push_done(logic [PFS_SP_W-1:0] old_sp, logic [PFS_REG_W-1:0] word);
        (sp_q == old_sp + PFS_SP_STEP) ##0 (stk_rd == word);
    endsequence

    sequence s_pop_done(logic [PFS_SP_W-1:0] old_sp, logic [PFS_REG_W-1:0] word);
        (sp_q == old_sp - PFS_SP_STEP) ##0 (POP_DATA == word);
    endsequence

    a_reset_values: assert property (
        boot_q |-> (ip_q == PFS_IP_RST) && (sp_q == PFS_SP_RST[PFS_SP_W-1:0]))
        else $error("reset values of pointers wrong");

    a_fetch_step: assert property (
        FETCH_STROBE && !call_go && !wr_ip |=> FETCH_ADDR == $past(ip_q) + PFS_IP_STEP)
        else $error("fetch pointer did not step by one");

    a_ip_branch: assert property (
        wr_ip |=> FETCH_ADDR == $past(PWDATA[PFS_REG_W-1:0]))
        else $error("write to fetch pointer did not branch");

    a_read_quiet: assert property (
        PSEL && !PWRITE && hit_ip && !FETCH_STROBE && !call_go |=> $stable(FETCH_ADDR))
        else $error("fetch pointer read changed flow");

    a_pop_order: assert property (
        pop_go && !call_go |=> s_pop_done($past(sp_q), $past(stk_rd)))
        else $error("pop order wrong");

    a_push_order: assert property (
        push_go |=> s_push_done($past(sp_q), $past(PUSH_DATA)))
        else $error("push order wrong");

    a_sp_upper_zero: assert property (
        access_ph && !PWRITE && hit_sp |-> PRDATA[PFS_APB_DW-1:PFS_SP_W] == '0)
        else $error("stack pointer upper bits not zero");

    a_vector_fixed: assert property (
        ##1 (vec_q == PFS_VEC_RST) && !(wr_ok && hit_vec && !PSLVERR))
        else $error("vector register changed or write accepted");

    a_irq_call: assert property (
        call_go |=> (FETCH_ADDR == vec_q) ##0 s_push_done($past(sp_q), $past(ret_addr)))
        else $error("interrupt call sequence wrong");

    a_irq_taken: assert property (
        IRQ_PENDING && !PUSH_STROBE && !POP_STROBE && !(PSEL && PENABLE && PWRITE) |-> IRQ_ACK)
        else $error("pending interrupt not taken");

    a_sp_wrap: assert property (
        push_go && (sp_q == PFS_SP_MAX) |=> sp_q == PFS_SP_MIN)
        else $error("stack pointer did not wrap");

    a_sp_reset: assert property (
        boot_q |-> STACK_TOP == PFS_SP_RST[PFS_SP_W-1:0])
        else $error("stack pointer reset value wrong");

    a_vector_readback: assert property (
        access_ph && !PWRITE && hit_vec |-> PRDATA == PFS_APB_DW'(PFS_VEC_RST))
        else $error("vector register read value wrong");

    a_loop_write: assert property (
        wr_loop |=> LOOP_COUNT == $past(PWDATA[PFS_REG_W-1:0]))
        else $error("loop counter write lost");

    a_push_beats_pop: assert property (
        PUSH_STROBE && POP_STROBE && !wr_sp |=> STACK_TOP == $past(sp_q) + PFS_SP_STEP)
        else $error("push and pop together not handled as push");

    a_call_over_fetch: assert property (
        call_go && FETCH_STROBE |=> s_push_done($past(sp_q), $past(ip_q) + PFS_IP_STEP))
        else $error("return address after fetch wrong");

endmodule

`default_nettype wire

// [sim/test_program_flow_stack_regs.sv]
// self-checking bench for the program flow and stack register block
`timescale 1ns/1ps
`default_nettype none

module test_program_flow_stack_regs
    import pfs_pkg::*;
;
    // ***************************************************************
    // signals and bookkeeping
    // ***************************************************************
    logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic fetch_strobe = 1'b0, push_strobe = 1'b0, pop_strobe = 1'b0, irq_pending = 1'b0;
    logic [15:0] push_data = 16'h0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq_ack;
    logic [15:0] fetch_addr, pop_data, loop_count;
    logic [5:0] stack_top;
    int n_fail = 0, n_checks = 0, seed = 52, k;
    logic [32:0] rd_q[$];
    logic [15:0] pop_q[$];
    logic [15:0] mem_m[64];
    logic [15:0] ip_m, v;
    logic [5:0] sp_m;
    logic pop_d = 1'b0;

    initial begin
        forever #4 clock = ~clock;
    end

    pfs_flow_regs pfs_flow_regs_inst (
        .CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FETCH_STROBE(fetch_strobe), .FETCH_ADDR(fetch_addr), .PUSH_STROBE(push_strobe),
        .PUSH_DATA(push_data), .POP_STROBE(pop_strobe), .POP_DATA(pop_data),
        .STACK_TOP(stack_top), .IRQ_PENDING(irq_pending), .IRQ_ACK(irq_ack), .LOOP_COUNT(loop_count)
    );

    // ***************************************************************
    // compare and closing tasks
    // ***************************************************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk33(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ***************************************************************
    // drivers
    // ***************************************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        rd_q.push_back(exp);
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            end_of_test();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic step(input logic f, input logic pu, input logic po, input logic irq, input logic [15:0] d);
        @(posedge clock);
        fetch_strobe <= f;
        push_strobe <= pu;
        pop_strobe <= po;
        irq_pending <= irq;
        push_data <= d;
    endtask

    task automatic pop_one();
        step(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
        pop_q.push_back(mem_m[sp_m]);
        sp_m--;
    endtask

    // ***************************************************************
    // result monitor
    // ***************************************************************
    always @(posedge clock) begin
        if (psel && penable && pready && rd_q.size() > 0) begin
            chk33(pwrite ? {pslverr, 32'h0} : {pslverr, prdata}, rd_q.pop_front());
        end
        if (pop_d && pop_q.size() > 0) begin
            chk16(pop_data, pop_q.pop_front());
        end
        pop_d <= pop_strobe & ~push_strobe;
    end

    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        foreach (mem_m[i]) mem_m[i] = 16'h0000;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        ip_m = 16'h8000;
        sp_m = 6'h2F;
        #1 chk16(fetch_addr, ip_m);
        chk16({10'h0, stack_top}, 16'h002F);
        apb(1'b0, PFS_OFF_IP, 32'h0, {1'b0, 32'h8000});
        apb(1'b0, PFS_OFF_SP, 32'h0, {1'b0, 32'h002F});
        apb(1'b0, PFS_OFF_VEC, 32'h0, {1'b0, 32'h07FD});
        apb(1'b0, PFS_OFF_LOOP, 32'h0, 33'h0);
        k = 1 + ($random(seed) & 7);
        repeat (k) step(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
        step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        ip_m = ip_m + 16'(k);
        #1 chk16(fetch_addr, ip_m);
        apb(1'b0, PFS_OFF_IP, 32'h0, {17'h0, ip_m});
        #1 chk16(fetch_addr, ip_m);
        v = 16'($random(seed));
        apb(1'b1, PFS_OFF_IP, {16'hA5A5, v}, 33'h0);
        ip_m = v + 16'h0001;
        #1 chk16(fetch_addr, v);
        step(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
        step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        #1 chk16(fetch_addr, ip_m);
        apb(1'b1, PFS_OFF_VEC, 32'h0000_1234, {1'b1, 32'h0});
        apb(1'b0, PFS_OFF_VEC, 32'h0, {1'b0, 32'h07FD});
        apb(1'b1, 8'h10, 32'h0000_FFFF, {1'b1, 32'h0});
        apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
        apb(1'b1, PFS_OFF_SP, 32'hFFFF_FFFE, 33'h0);
        sp_m = 6'h3E;
        apb(1'b0, PFS_OFF_SP, 32'h0, {1'b0, 32'h0000_003E});
        // push across the wrap, then pop back
        for (k = 0; k < 3; k++) begin
            v = 16'($random(seed));
            step(1'b0, 1'b1, 1'b0, 1'b0, v);
            sp_m++;
            mem_m[sp_m] = v;
        end
        step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        #1 chk16({10'h0, stack_top}, {10'h0, sp_m});
        repeat (3) pop_one();
        step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        #1 chk16({10'h0, stack_top}, {10'h0, sp_m});
        // call deferred by a push, then taken
        v = 16'($random(seed));
        step(1'b0, 1'b1, 1'b0, 1'b1, v);
        sp_m++;
        mem_m[sp_m] = v;
        #1 chk16({15'h0, irq_ack}, 16'h0000);
        step(1'b1, 1'b0, 1'b0, 1'b1, 16'h0000);
        #1 chk16({15'h0, irq_ack}, 16'h0001);
        step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        sp_m++;
        mem_m[sp_m] = ip_m + 16'h0001;
        #1 chk16(fetch_addr, 16'h07FD);
        chk16({10'h0, stack_top}, {10'h0, sp_m});
        repeat (2) pop_one();
        step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        // push and pop together, pop ignored
        v = 16'($random(seed));
        step(1'b0, 1'b1, 1'b1, 1'b0, v);
        sp_m++;
        mem_m[sp_m] = v;
        pop_one();
        step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        #1 chk16({10'h0, stack_top}, {10'h0, sp_m});
        v = 16'($random(seed));
        apb(1'b1, PFS_OFF_LOOP, {16'h0, v}, 33'h0);
        apb(1'b0, PFS_OFF_LOOP, 32'h0, {17'h0, v});
        #1 chk16(loop_count, v);
        @(posedge clock);
        rstn <= 1'b0;
        #1 chk16(fetch_addr, 16'h8000);
        chk16({10'h0, stack_top}, 16'h002F);
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, PFS_OFF_SP, 32'h0, {1'b0, 32'h0000_002F});
        repeat (3) @(posedge clock);
        end_of_test();
    end
endmodule

`default_nettype wire
